// file: hw/dbseq_pkg.sv
// Constants and types shared by the dual buck sequencer
package dbseq_pkg;
   // Clock and oscillator
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned OSC_BASE_HZ = 2_400_000;
   localparam int unsigned OSC_TICK_CYC = CLK_HZ / OSC_BASE_HZ;
   // Variant divide ratios
   localparam int unsigned DIV_SLOW = 8;
   localparam int unsigned DIV_MID = 4;
   localparam int unsigned DIV_FAST = 2;
   // Soft-start times in microseconds
   localparam int unsigned SS_SLOW_US = 5200;
   localparam int unsigned SS_MID_US = 2600;
   localparam int unsigned SS_FAST_US = 1300;
   localparam int unsigned SS_STEPS = 256;
   localparam int unsigned SKIP_PULSES = 6;
   localparam int unsigned HICCUP_US = 5200;
   localparam int unsigned US_CYC = CLK_HZ / 1_000_000;
   localparam int unsigned HICCUP_CYC = HICCUP_US * US_CYC;
   // Register map (word offsets as byte addresses)
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_IRQ_STAT = 8'h08;
   localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
   localparam logic [7:0] REG_REF1 = 8'h10;
   localparam logic [7:0] REG_REF2 = 8'h14;
   // Interrupt bit positions
   localparam int unsigned IRQ_UV = 0;
   localparam int unsigned IRQ_OC1 = 1;
   localparam int unsigned IRQ_OC2 = 2;
   localparam int unsigned IRQ_REG1 = 3;
   localparam int unsigned IRQ_REG2 = 4;
   localparam int unsigned IRQ_W = 5;
   localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

   typedef enum logic [2:0] {
      ST_LOCKOUT = 3'b000,
      ST_SHUTDOWN = 3'b001,
      ST_BOOT = 3'b011,
      ST_RUN = 3'b010,
      ST_HICCUP = 3'b110
   } dbseq_state_t;
endpackage

// file: hw/dbseq_top.sv
// Dual buck converter sequencing and protection logic
`timescale 1ns/1ps
// Functional notes
// - Switching ramp is base oscillator divided by variant
// - Channels switch on alternating cycles
// - Supply lockout holds all switches off
// - Bootstrap regulator on after lockout, any enable
// - PWM and soft-start wait for regulator good
// - Low enable starts that channel's soft-start
// - Both enables high gives shutdown, regulator off
// - Enable released: channel switches off immediately
// - Digital soft-start ramp, variant-dependent duration
// - Ramp end holds target at full reference
// - Overcurrent in soft-start skips six pulses
// - No skipping without a current-limit pulse
// - Output low at ramp end trips hiccup
// - Output low: stop both, hiccup wait, restart
// - After regulation, limit overcurrent without skipping
module dbseq_top
   import dbseq_pkg::*;
#(
   parameter int unsigned DIV_RATIO = DIV_SLOW,
   parameter int unsigned SS_US = SS_SLOW_US,
   parameter int unsigned HICCUP_CYCLES = HICCUP_CYC,
   parameter int unsigned REF_W = 8
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Wishbone classic slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Pins and comparators
   input wire logic output1_enable_n_i,
   input wire logic output2_enable_n_i,
   input wire logic supply_good_i,
   input wire logic regulator_good_i,
   input wire logic [1:0] overcurrent_i,
   input wire logic [1:0] output_low_fault_i,
   output logic bootstrap_regulator_en_o,
   output logic [1:0] pwm_enable_o,
   output logic [1:0] pulse_o,
   output logic [1:0] upper_off_o,
   output logic [1:0] lower_off_o,
   output logic irq_o
);
   localparam int unsigned PER_CYC = OSC_TICK_CYC * DIV_RATIO;
   localparam int unsigned SS_STEP_CYC = (SS_US * US_CYC) / SS_STEPS;
   localparam int unsigned CW = $clog2(HICCUP_CYCLES + SS_STEP_CYC + PER_CYC + 2);
   localparam logic [REF_W-1:0] REF_FULL = '1;

   // -----------------------------------------------------------------
   // Input synchronisers
   // -----------------------------------------------------------------
   logic [7:0] sy1_q, sy2_q;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sy1_q <= 8'h00;
         sy2_q <= 8'h00;
      end else if (ce_i) begin
         sy1_q <= {output1_enable_n_i, output2_enable_n_i, supply_good_i, regulator_good_i,
                   overcurrent_i, output_low_fault_i};
         sy2_q <= sy1_q;
      end
   end
   wire en1_n = sy2_q[7];
   wire en2_n = sy2_q[6];
   wire sup_ok = sy2_q[5];
   wire reg_ok = sy2_q[4];
   wire [1:0] oc = sy2_q[3:2];
   wire [1:0] low = sy2_q[1:0];
   wire [1:0] ch_en = {~en2_n, ~en1_n};

   // -----------------------------------------------------------------
   // Switching clock and phase
   // -----------------------------------------------------------------
   logic [CW-1:0] per_q;
   logic phase_q;
   wire per_end = (per_q == CW'(PER_CYC - 1));
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         per_q <= '0;
         phase_q <= 1'b0;
      end else if (ce_i) begin
         per_q <= per_end ? '0 : per_q + 1'b1;
         if (per_end)
            phase_q <= ~phase_q;
      end
   end
   wire [1:0] cyc_start = {per_end & phase_q, per_end & ~phase_q};

   // -----------------------------------------------------------------
   // Sequencer
   // -----------------------------------------------------------------
   dbseq_state_t st_q, st_d;
   logic [CW-1:0] hic_q;
   logic [REF_W-1:0] ref_q [2];
   logic [1:0] done_q, uv_trip;
   logic [1:0] soft_en_q;
   wire any_en = |ch_en;
   wire hic_done = (hic_q == CW'(HICCUP_CYCLES - 1));
   wire uv_fault = |uv_trip;

   always_comb begin
      st_d = st_q;
      unique case (st_q)
         ST_LOCKOUT: if (sup_ok) st_d = ST_SHUTDOWN;
         ST_SHUTDOWN: if (any_en) st_d = ST_BOOT;
         ST_BOOT: if (!any_en) st_d = ST_SHUTDOWN;
                  else if (reg_ok) st_d = ST_RUN;
         ST_RUN: if (!any_en) st_d = ST_SHUTDOWN;
                 else if (uv_fault) st_d = ST_HICCUP;
         ST_HICCUP: if (hic_done) st_d = ST_SHUTDOWN;
         default: st_d = ST_LOCKOUT;
      endcase
      if (!sup_ok)
         st_d = ST_LOCKOUT;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q <= ST_LOCKOUT;
         hic_q <= '0;
      end else if (ce_i) begin
         st_q <= st_d;
         hic_q <= (st_q == ST_HICCUP) ? hic_q + 1'b1 : '0;
      end
   end
   wire running = (st_q == ST_RUN);
   assign bootstrap_regulator_en_o = (st_q == ST_BOOT) || running;

   // -----------------------------------------------------------------
   // Per-channel soft-start, skipping and switch control
   // -----------------------------------------------------------------
   logic [CW-1:0] step_q [2];
   logic [2:0] skip_q [2];
   logic [1:0] pulse_q;
   logic [1:0] act;
   wire [1:0] oc_pulse = pulse_q & oc;
   for (genvar c = 0; c < 2; c++) begin : g_ch
      assign act[c] = running & ch_en[c];
      assign uv_trip[c] = act[c] & done_q[c] & low[c];
      wire step_end = (step_q[c] == CW'(SS_STEP_CYC - 1));
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            step_q[c] <= '0;
            ref_q[c] <= '0;
            done_q[c] <= 1'b0;
            skip_q[c] <= 3'd0;
            pulse_q[c] <= 1'b0;
         end else if (ce_i) begin
            if (!act[c]) begin
               step_q[c] <= '0;
               ref_q[c] <= '0;
               done_q[c] <= 1'b0;
               skip_q[c] <= 3'd0;
            end else if (!done_q[c]) begin
               step_q[c] <= step_end ? '0 : step_q[c] + 1'b1;
               if (step_end && ref_q[c] == REF_FULL)
                  done_q[c] <= 1'b1;
               else if (step_end)
                  ref_q[c] <= ref_q[c] + 1'b1;
            end
            if (act[c] && !done_q[c] && oc_pulse[c])
               skip_q[c] <= 3'(SKIP_PULSES);
            else if (act[c] && cyc_start[c] && skip_q[c] != 3'd0)
               skip_q[c] <= skip_q[c] - 3'd1;
            // Pulse ends on overcurrent, each cycle
            if (!act[c] || oc_pulse[c])
               pulse_q[c] <= 1'b0;
            else if (cyc_start[c] && skip_q[c] == 3'd0)
               pulse_q[c] <= 1'b1;
            else if (cyc_start[c ^ 1])
               pulse_q[c] <= 1'b0;
         end
      end
   end
   assign pwm_enable_o = act;
   assign pulse_o = pulse_q;
   assign upper_off_o = ~act;
   assign lower_off_o = ~act;

   // -----------------------------------------------------------------
   // Interrupts and register bus
   // -----------------------------------------------------------------
   logic [IRQ_W-1:0] ist_q, imask_q;
   logic [1:0] done_d1_q;
   logic force_off_q;
   wire [IRQ_W-1:0] ev = {done_q[1] & ~done_d1_q[1], done_q[0] & ~done_d1_q[0],
                          oc_pulse[1], oc_pulse[0], uv_fault & running};
   wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   // Writes land at the edge where the master sees ack
   wire wr = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];
   wire wr_ctrl = wr && (wb_adr_i == REG_CTRL);
   wire wr_clr = wr && (wb_adr_i == REG_IRQ_STAT);
   wire wr_mask = wr && (wb_adr_i == REG_IRQ_MASK);
   wire [31:0] rd_mux =
      (wb_adr_i == REG_CTRL) ? {31'h0, force_off_q} :
      (wb_adr_i == REG_STATUS) ? {24'h0, st_q, done_q, act, sup_ok} :
      (wb_adr_i == REG_IRQ_STAT) ? {27'h0, ist_q} :
      (wb_adr_i == REG_IRQ_MASK) ? {27'h0, imask_q} :
      (wb_adr_i == REG_REF1) ? 32'(ref_q[0]) :
      (wb_adr_i == REG_REF2) ? 32'(ref_q[1]) : UNMAPPED_DATA;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ist_q <= '0;
         imask_q <= '0;
         done_d1_q <= 2'b00;
         force_off_q <= 1'b0;
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else if (ce_i) begin
         done_d1_q <= done_q;
         ist_q <= (ist_q & ~(wr_clr ? wb_dat_i[IRQ_W-1:0] : '0)) | ev;
         if (wr_mask)
            imask_q <= wb_dat_i[IRQ_W-1:0];
         if (wr_ctrl)
            force_off_q <= wb_dat_i[0];
         wb_ack_o <= req;
         if (req)
            wb_dat_o <= rd_mux;
      end
   end
   assign irq_o = |(ist_q & imask_q);

   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   sequence s_oc_in_ss(c);
      act[c] && !done_q[c] && oc_pulse[c];
   endsequence
   property p_lockout_off;
      @(posedge clk_i) disable iff (rst_i) (st_q == ST_LOCKOUT) |-> (act == 2'b00);
   endproperty
   a_lockout_off: assert property (p_lockout_off) else $error("switching in lockout");
   property p_boot_on;
      @(posedge clk_i) disable iff (rst_i)
         ce_i && st_q == ST_SHUTDOWN && any_en && sup_ok |=> bootstrap_regulator_en_o;
   endproperty
   a_boot_on: assert property (p_boot_on) else $error("regulator not on");
   property p_pwm_needs_reg;
      @(posedge clk_i) disable iff (rst_i) $rose(act[0]) |-> $past(reg_ok);
   endproperty
   a_pwm_needs_reg: assert property (p_pwm_needs_reg) else $error("pwm before good");
   property p_shutdown;
      @(posedge clk_i) disable iff (rst_i)
         ce_i && running && ch_en == 2'b00 |=> !bootstrap_regulator_en_o;
   endproperty
   a_shutdown: assert property (p_shutdown) else $error("no shutdown");
   property p_off_now;
      @(posedge clk_i) disable iff (rst_i) !ch_en[0] |-> upper_off_o[0] && lower_off_o[0];
   endproperty
   a_off_now: assert property (p_off_now) else $error("switch on while off");
   property p_skip;
      @(posedge clk_i) disable iff (rst_i) ce_i and s_oc_in_ss(0) |=> skip_q[0] == 3'd6;
   endproperty
   a_skip: assert property (p_skip) else $error("skip not loaded");
   property p_no_skip;
      @(posedge clk_i) disable iff (rst_i)
         ce_i && done_q[0] && skip_q[0] == 3'd0 |=> skip_q[0] == 3'd0 || !done_q[0];
   endproperty
   a_no_skip: assert property (p_no_skip) else $error("skip after regulation");
   property p_hiccup;
      @(posedge clk_i) disable iff (rst_i)
         ce_i && running && any_en && sup_ok && uv_fault |=> st_q == ST_HICCUP ##1 act == 2'b00;
   endproperty
   a_hiccup: assert property (p_hiccup) else $error("no hiccup");
   property p_ref_hold;
      @(posedge clk_i) disable iff (rst_i) done_q[0] && act[0] |-> ref_q[0] == REF_FULL;
   endproperty
   a_ref_hold: assert property (p_ref_hold) else $error("ref not held");
endmodule // dbseq_top

// file: bench/dbseq_partner.sv
// Model of the enable circuitry, supply monitors and both power stages
`timescale 1ns/1ps
module dbseq_partner (
   input wire logic clk_i,
   input wire logic supply_on_i,
   input wire logic [1:0] enable_n_req_i,
   input wire logic [1:0] oc_req_i,
   input wire logic [1:0] low_req_i,
   input wire logic bootstrap_regulator_en_i,
   input wire logic [1:0] pulse_i,
   output logic output1_enable_n_o,
   output logic output2_enable_n_o,
   output logic supply_good_o,
   output logic regulator_good_o,
   output logic [1:0] overcurrent_o,
   output logic [1:0] output_low_fault_o
);
   int unsigned charge_q;

   // ----------------------------------------
   // Regulator capacitor charging
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      if (!bootstrap_regulator_en_i) begin
         charge_q <= 0;
      end else if (charge_q < 20) begin
         charge_q <= charge_q + 1;
      end
   end

   // ----------------------------------------
   // Comparators
   // ----------------------------------------
   assign regulator_good_o = (charge_q >= 20);
   assign supply_good_o = supply_on_i;
   assign output1_enable_n_o = enable_n_req_i[0];
   assign output2_enable_n_o = enable_n_req_i[1];
   // Current only flows while the upper switch conducts
   assign overcurrent_o = oc_req_i & pulse_i;
   assign output_low_fault_o = low_req_i;
endmodule // dbseq_partner

// file: bench/test_dbseq_top.sv
// Self-checking bench for the dual buck sequencer
`timescale 1ns/1ps
module test_dbseq_top;
   import dbseq_pkg::*;
   localparam int unsigned DIV = DIV_FAST;
   localparam int unsigned SS = 100;
   localparam int PER = OSC_TICK_CYC * DIV;
   localparam int RAMP = SS_STEPS * ((SS * US_CYC) / SS_STEPS);
   logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, sup = 0, ack;
   logic [7:0] adr = 8'h00;
   logic [31:0] wd = 32'h0000_0000, rd, q;
   logic [1:0] en_n = 2'b00, oc = 2'b00, low = 2'b00;
   logic [1:0] pwm, pulse, up_off, lo_off, ocf, lowf;
   logic e1, e2, sg, rg, boot, irq;
   int errors = 0, comparisons = 0, cyc_n = 0, t0, t1, t2, d;

   always #5 clk_i = ~clk_i;

   dbseq_top #(.DIV_RATIO(DIV), .SS_US(SS), .HICCUP_CYCLES(200)) dut (
      .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(rd),
      .wb_ack_o(ack), .output1_enable_n_i(e1), .output2_enable_n_i(e2),
      .supply_good_i(sg), .regulator_good_i(rg), .overcurrent_i(ocf),
      .output_low_fault_i(lowf), .bootstrap_regulator_en_o(boot), .pwm_enable_o(pwm),
      .pulse_o(pulse), .upper_off_o(up_off), .lower_off_o(lo_off), .irq_o(irq));

   dbseq_partner far (
      .clk_i(clk_i), .supply_on_i(sup), .enable_n_req_i(en_n), .oc_req_i(oc),
      .low_req_i(low), .bootstrap_regulator_en_i(boot), .pulse_i(pulse),
      .output1_enable_n_o(e1), .output2_enable_n_o(e2), .supply_good_o(sg),
      .regulator_good_o(rg), .overcurrent_o(ocf), .output_low_fault_o(lowf));

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic tick(input int k);
      repeat (k) @(posedge clk_i);
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] v);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wd <= v;
      do begin
         @(posedge clk_i);
      end while (ack !== 1'b1);
      q = rd;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task automatic rise(input int ch, output int t);
      int n;
      n = 0;
      while (pulse[ch] !== 1'b0 && n < 5000) begin
         tick(1);
         n++;
      end
      while (pulse[ch] !== 1'b1 && n < 5000) begin
         tick(1);
         n++;
      end
      if (n >= 5000) errors++;
      t = cyc_n;
   endtask

   task automatic conclude;
      $display("errors=%0d comparisons=%0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   always @(posedge clk_i) begin
      cyc_n <= cyc_n + 1;
      if (cyc_n == 30000) begin
         errors++;
         conclude();
      end
   end

   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial begin
      tick(20);
      rst_i <= 1'b0;
      tick(20);
      chk(boot, 0);
      chk(pwm | pulse, 0);
      chk(up_off & lo_off, 2'b11);
      sup <= 1'b1;
      en_n <= 2'b11;
      tick(10);
      chk(boot, 0);
      xfer(0, REG_STATUS, 0);
      chk(q[7:5], ST_SHUTDOWN);
      en_n <= 2'b00;
      tick(6);
      chk(boot, 1);
      chk(pwm, 0);
      tick(30);
      chk(pwm, 2'b11);
      t2 = cyc_n;
      xfer(1, REG_IRQ_MASK, 32'h0000_0002);
      rise(0, t0);
      rise(1, t1);
      chk(t1 - t0, PER);
      rise(0, t1);
      chk(t1 - t0, 2 * PER);
      oc <= 2'b01;
      rise(0, t0);
      tick(10);
      oc <= 2'b00;
      rise(0, t1);
      chk(t1 - t0, 14 * PER);
      chk(irq, 1);
      xfer(1, REG_IRQ_STAT, 32'h0000_0002);
      tick(2);
      chk(irq, 0);
      xfer(0, REG_REF1, 0);
      chk(q > 0 && q < 255, 1);
      q = 32'h0000_0000;
      t0 = 0;
      while (!q[IRQ_REG1] && t0 < 9000) begin
         xfer(0, REG_IRQ_STAT, 0);
         t0++;
      end
      d = cyc_n - t2 - RAMP;
      chk(d > -100 && d < 100, 1);
      xfer(0, REG_REF1, 0);
      chk(q, 32'h0000_00FF);
      tick(100);
      xfer(0, REG_REF2, 0);
      chk(q, 32'h0000_00FF);
      oc <= 2'b01;
      rise(0, t0);
      rise(0, t1);
      oc <= 2'b00;
      chk(t1 - t0, 2 * PER);
      tick(10);
      low <= 2'b01;
      tick(6);
      chk(pwm, 0);
      chk(up_off & lo_off, 2'b11);
      tick(100);
      chk(pwm | pulse, 0);
      low <= 2'b00;
      t0 = 0;
      while (pwm !== 2'b11 && t0 < 400) begin
         tick(1);
         t0++;
      end
      chk(t0 < 400, 1);
      xfer(0, REG_IRQ_STAT, 0);
      chk(q[IRQ_UV], 1);
      en_n <= 2'b01;
      tick(5);
      chk(pwm, 2'b10);
      chk({up_off[0], lo_off[0]}, 2'b11);
      en_n <= 2'b11;
      tick(5);
      chk(boot, 0);
      chk(pwm, 0);
      xfer(1, REG_CTRL, 32'h0000_0001);
      xfer(0, REG_CTRL, 0);
      chk(q[0], 1);
      xfer(0, 8'h40, 0);
      chk(q, UNMAPPED_DATA);
      conclude();
   end
endmodule // test_dbseq_top
